/* hw/tdrp_pkg.sv */
// Package: offsets, field layouts and reset values of the trace driver rate registers
package tdrp_pkg;

   // ************************************************************
   // Register map (word addresses of the serial control port)
   // ************************************************************
   localparam int          TDRP_AW           = 12;
   localparam int          TDRP_DW           = 16;
   localparam logic [11:0] TDRP_OUT0_HD_EMPH = 12'h02e;
   localparam logic [11:0] TDRP_OUT0_HD_SWNG = 12'h02f;
   localparam logic [11:0] TDRP_OUT1_3G_EMPH = 12'h030;
   localparam logic [11:0] TDRP_OUT1_3G_SWNG = 12'h031;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int WIDTH_LSB = 8;
   localparam int WIDTH_MSB = 12;
   localparam int OFF_BIT   = 6;
   localparam int LEVEL_LSB = 0;
   localparam int LEVEL_MSB = 5;
   localparam int SWING_LSB = 8;
   localparam int SWING_MSB = 13;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [4:0]  WIDTH_RST     = 5'h02;
   localparam logic        OFF_RST       = 1'h0;
   localparam logic [5:0]  LEVEL_RST     = 6'h01;
   localparam logic [5:0]  SWING_RST     = 6'h11;   // Nominal 400 mV ppd
   localparam logic [15:0] EMPH_REG_RST  = 16'h0201;
   localparam logic [15:0] SWING_REG_RST = 16'h1170;

   // Rate selection of the retimer
   typedef enum logic [1:0] {
      TDRP_RATE_OTHER = 2'b00,
      TDRP_RATE_HD    = 2'b01,
      TDRP_RATE_3G    = 2'b10
   } tdrp_rate_e;

endpackage

/* hw/tdrp_reg16.sv */
// One 16-bit read/write register with a reset value
`timescale 1ns/1ns
`default_nettype none
module tdrp_reg16 #(
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   output logic      [15:0] value
);

   // Whole word is stored, reserved bits included
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         value <= RST_VAL;
      end else if (wr_en) begin
         value <= wr_data;
      end
   end

endmodule
`default_nettype wire

/* hw/tdrp_drv_sel.sv */
// Picks the active driver settings of one output by line rate
`timescale 1ns/1ns
`default_nettype none
module tdrp_drv_sel
   import tdrp_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst_b,
   input  wire tdrp_pkg::tdrp_rate_e rate,
   input  wire logic            rate_match,
   input  wire logic [15:0]     emph_reg,
   input  wire logic [15:0]     swing_reg,
   output logic      [4:0]      pulse_width,
   output logic                 emph_off,
   output logic      [5:0]      emph_level,
   output logic      [5:0]      swing_level
);

   // Matching rate applies the stored set; otherwise the last applied settings are held
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pulse_width <= WIDTH_RST;
         emph_off    <= OFF_RST;
         emph_level  <= LEVEL_RST;
         swing_level <= SWING_RST;
      end else if (rate_match && rate != TDRP_RATE_OTHER) begin
         pulse_width <= emph_reg[WIDTH_MSB:WIDTH_LSB];
         emph_off    <= emph_reg[OFF_BIT];
         emph_level  <= emph_reg[LEVEL_MSB:LEVEL_LSB];
         swing_level <= swing_reg[SWING_MSB:SWING_LSB];
      end
   end

endmodule
`default_nettype wire

/* hw/tdrp_regs.sv */
// Trace driver per-rate parameter registers for two serial outputs
`timescale 1ns/1ns
`default_nettype none
module tdrp_regs
   import tdrp_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [TDRP_AW-1:0]      reg_addr,
   input  wire logic [TDRP_DW-1:0]      reg_wdata,
   output logic      [TDRP_DW-1:0]      reg_rdata,
   output logic                         reg_hit,
   input  wire tdrp_pkg::tdrp_rate_e    out0_rate,
   input  wire tdrp_pkg::tdrp_rate_e    out1_rate,
   output logic      [4:0]              out0_hd_pulse_width,
   output logic                         out0_hd_emph_off,
   output logic      [5:0]              out0_hd_emph_level,
   output logic      [5:0]              out0_hd_swing_level,
   output logic      [4:0]              out1_3g_pulse_width,
   output logic                         out1_3g_emph_off,
   output logic      [5:0]              out1_3g_emph_level,
   output logic      [5:0]              out1_3g_swing_level
);

   // ************************************************************
   // Address decode
   // ************************************************************
   wire logic [3:0] sel;
   assign sel[0] = reg_addr == TDRP_OUT0_HD_EMPH;
   assign sel[1] = reg_addr == TDRP_OUT0_HD_SWNG;
   assign sel[2] = reg_addr == TDRP_OUT1_3G_EMPH;
   assign sel[3] = reg_addr == TDRP_OUT1_3G_SWNG;

   wire logic [TDRP_DW-1:0] regs [4];

   // ************************************************************
   // Storage: reset words hold each field default
   // ************************************************************
   // Field defaults of pulse width, power down and amplitude
   tdrp_reg16 #(.RST_VAL(EMPH_REG_RST)) u_out0_hd_emph (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && sel[0]),
      .wr_data (reg_wdata),
      .value   (regs[0])
   );
   // Swing default 11h gives nominal 400 mV ppd
   tdrp_reg16 #(.RST_VAL(SWING_REG_RST)) u_out0_hd_swng (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && sel[1]),
      .wr_data (reg_wdata),
      .value   (regs[1])
   );
   tdrp_reg16 #(.RST_VAL(EMPH_REG_RST)) u_out1_3g_emph (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && sel[2]),
      .wr_data (reg_wdata),
      .value   (regs[2])
   );
   tdrp_reg16 #(.RST_VAL(SWING_REG_RST)) u_out1_3g_swng (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && sel[3]),
      .wr_data (reg_wdata),
      .value   (regs[3])
   );

   // ************************************************************
   // Read port: full word, reserved bits as written
   // ************************************************************
   wire logic [TDRP_DW-1:0] rd_mux;
   assign rd_mux = sel[0] ? regs[0] :
                   sel[1] ? regs[1] :
                   sel[2] ? regs[2] :
                   sel[3] ? regs[3] : 16'h0000;

   // Registered read data, one cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
         reg_hit   <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
         reg_hit   <= |sel;
      end
   end

   // ************************************************************
   // Driver settings per output and rate
   // ************************************************************
   wire logic out0_hd;
   wire logic out1_3g;
   assign out0_hd = out0_rate == TDRP_RATE_HD;
   assign out1_3g = out1_rate == TDRP_RATE_3G;

   // Output 0 follows the HD set only while at HD rate
   tdrp_drv_sel u_out0_sel (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .rate        (out0_rate),
      .rate_match  (out0_hd),
      .emph_reg    (regs[0]),
      .swing_reg   (regs[1]),
      .pulse_width (out0_hd_pulse_width),
      .emph_off    (out0_hd_emph_off),
      .emph_level  (out0_hd_emph_level),
      .swing_level (out0_hd_swing_level)
   );

   // Output 1 follows the 3G set only while at 3G rate
   tdrp_drv_sel u_out1_sel (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .rate        (out1_rate),
      .rate_match  (out1_3g),
      .emph_reg    (regs[2]),
      .swing_reg   (regs[3]),
      .pulse_width (out1_3g_pulse_width),
      .emph_off    (out1_3g_emph_off),
      .emph_level  (out1_3g_emph_level),
      .swing_level (out1_3g_swing_level)
   );

endmodule
`default_nettype wire

/* sim/tdrp_regs_properties.sv */
// Checker of read and driver output timing of the rate register bank
`timescale 1ns/1ns
`default_nettype none
module tdrp_regs_properties
   import tdrp_pkg::*;
(
   input wire logic                 mclk,
   input wire logic                 rst_b,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [11:0]          reg_addr,
   input wire logic [15:0]          reg_wdata,
   input wire logic [15:0]          reg_rdata,
   input wire logic                 reg_hit,
   input wire tdrp_pkg::tdrp_rate_e out0_rate,
   input wire tdrp_pkg::tdrp_rate_e out1_rate,
   input wire logic [4:0]           out0_hd_pulse_width,
   input wire logic                 out0_hd_emph_off,
   input wire logic [5:0]           out0_hd_emph_level,
   input wire logic [5:0]           out0_hd_swing_level,
   input wire logic [4:0]           out1_3g_pulse_width,
   input wire logic                 out1_3g_emph_off,
   input wire logic [5:0]           out1_3g_emph_level,
   input wire logic [5:0]           out1_3g_swing_level
);
   // ************************************************************
   // Properties
   // ************************************************************
   wire logic        mapped = reg_addr >= TDRP_OUT0_HD_EMPH && reg_addr <= TDRP_OUT1_3G_SWNG;
   wire logic [12:0] e0 = {out0_hd_pulse_width, 1'b0, out0_hd_emph_off, out0_hd_emph_level};
   wire logic [12:0] e1 = {out1_3g_pulse_width, 1'b0, out1_3g_emph_off, out1_3g_emph_level};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_reset_values:
   assert property (disable iff (1'b0) !rst_b |=> e0 == 13'h0201 && e1 == 13'h0201
      && out0_hd_swing_level == 6'h11 && out1_3g_swing_level == 6'h11 && !reg_hit
      && reg_rdata == 16'h0000) else $error("reset values wrong");
   chk_unmapped_read:
   assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000 && !reg_hit) else $error("unmapped read");
   chk_mapped_hit:
   assert property (reg_rd && mapped |=> reg_hit) else $error("mapped read missed");
   chk_rdata_hold:
   assert property (!reg_rd |=> $stable({reg_rdata, reg_hit})) else $error("read data moved");
   chk_rate_hold:
   assert property (out0_rate != TDRP_RATE_HD && out1_rate != TDRP_RATE_3G |=> $stable({e0, e1,
      out0_hd_swing_level, out1_3g_swing_level})) else $error("outputs moved off rate");
   chk_out0_emph:
   assert property (reg_wr && reg_addr == TDRP_OUT0_HD_EMPH ##1 out0_rate == TDRP_RATE_HD
      |=> e0 == ($past(reg_wdata[12:0], 2) & 13'h1f7f)) else $error("out0 emphasis wrong");
   chk_out0_swing:
   assert property (reg_wr && reg_addr == TDRP_OUT0_HD_SWNG ##1 out0_rate == TDRP_RATE_HD
      |=> out0_hd_swing_level == $past(reg_wdata[13:8], 2)) else $error("out0 swing wrong");
   chk_out1_emph:
   assert property (reg_wr && reg_addr == TDRP_OUT1_3G_EMPH ##1 out1_rate == TDRP_RATE_3G
      |=> e1 == ($past(reg_wdata[12:0], 2) & 13'h1f7f)) else $error("out1 emphasis wrong");
   chk_out1_swing:
   assert property (reg_wr && reg_addr == TDRP_OUT1_3G_SWNG ##1 out1_rate == TDRP_RATE_3G
      |=> out1_3g_swing_level == $past(reg_wdata[13:8], 2)) else $error("out1 swing wrong");
endmodule
`default_nettype wire

/* sim/tdrp_regs_bench.sv */
// Self-checking bench of the rate register bank
`timescale 1ns/1ns
`default_nettype none
module tdrp_regs_bench;
   import tdrp_pkg::*;
   // ************************************************************
   // Stimulus and checks
   // ************************************************************
   logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic        reg_hit, out0_hd_emph_off, out1_3g_emph_off;
   logic [4:0]  out0_hd_pulse_width, out1_3g_pulse_width;
   logic [5:0]  out0_hd_emph_level, out0_hd_swing_level, out1_3g_emph_level, out1_3g_swing_level;
   tdrp_rate_e  out0_rate = TDRP_RATE_OTHER, out1_rate = TDRP_RATE_OTHER;
   logic [15:0] m [4];
   logic [16:0] q [$];
   int          mismatches = 0, cmp_count = 0;
   wire logic [35:0] outs = {out0_hd_pulse_width, out0_hd_emph_off, out0_hd_emph_level,
      out0_hd_swing_level, out1_3g_pulse_width, out1_3g_emph_off, out1_3g_emph_level,
      out1_3g_swing_level};
   tdrp_regs dut (.*);
   always #5 mclk = ~mclk;
   function automatic logic [35:0] exp_outs();
      return {m[0][12:8], m[0][6], m[0][5:0], m[1][13:8], m[2][12:8], m[2][6], m[2][5:0],
         m[3][13:8]};
   endfunction
   task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus cycle; the read expectation is noted before the write lands
   task automatic xfer(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d);
      logic ok;
      ok = a >= 12'h02e && a <= 12'h031;
      if (r) q.push_back(ok ? {1'b1, m[2'(a - 12'h02e)]} : 17'h00000);
      if (w && ok) m[2'(a - 12'h02e)] = d;
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(posedge mclk) #1;
   endtask
   task automatic scan;
      for (int k = 0; k < 6; k++) xfer(0, 1, 12'h02d + 12'(k), 16'h0000);
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read results appear one cycle after the read is taken
   always @(posedge mclk) begin
      #2;
      if (rd_seen) cmp("read", {19'h0, q.pop_front()}, {19'h0, reg_hit, reg_rdata});
      rd_seen = reg_rd && rst_b;
   end
   initial begin
      #30000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      logic [15:0] d;
      logic [1:0]  i;
      logic [35:0] e;
      int          k;
      void'($urandom(38196));
      m = '{EMPH_REG_RST, SWING_REG_RST, EMPH_REG_RST, SWING_REG_RST};
      repeat (2) @(posedge mclk);
      #1 rst_b = 1'b1;
      cmp("reset outputs", exp_outs(), outs);
      scan();
      for (int n = 0; n < 40; n++) begin
         k = $urandom % 6;
         i = 2'(k - 1);
         // Fields stay in range and reserved bits keep their stored value
         d = k[0] ? {m[i][15:13], 5'($urandom % 16), m[i][7], 1'($urandom), 6'($urandom % 51)}
                  : {m[i][15:14], 6'($urandom % 41), m[i][7:0]};
         out0_rate = tdrp_rate_e'($urandom % 3);
         out1_rate = tdrp_rate_e'($urandom % 3);
         xfer(1, 1'($urandom), 12'h02d + 12'(k), d);
         xfer(0, 1, 12'h02d + 12'(k), 16'h0000);
      end
      out0_rate = TDRP_RATE_HD;
      out1_rate = TDRP_RATE_3G;
      repeat (2) xfer(0, 0, 12'h000, 16'h0000);
      e = exp_outs();
      cmp("applied outputs", e, outs);
      out0_rate = TDRP_RATE_OTHER;
      out1_rate = TDRP_RATE_OTHER;
      // Non-default words, so the second reset must really restore every field
      for (int j = 0; j < 4; j++) xfer(1, 0, 12'h02e + 12'(j), j[0] ? 16'h2870 : 16'h0f72);
      repeat (2) xfer(0, 0, 12'h000, 16'h0000);
      cmp("held outputs", e, outs);
      rst_b = 1'b0;
      repeat (2) xfer(0, 0, 12'h000, 16'h0000);
      rst_b = 1'b1;
      m = '{EMPH_REG_RST, SWING_REG_RST, EMPH_REG_RST, SWING_REG_RST};
      cmp("second reset", exp_outs(), outs);
      scan();
      repeat (2) xfer(0, 0, 12'h000, 16'h0000);
      tally_and_finish();
   end
endmodule
bind tdrp_regs tdrp_regs_properties chk (.*);
`default_nettype wire
